// ### rtl/pwm_time_base_control.sv
/*
 * Time-base counter control: sync-out select, shadowed period, phase load, count modes,
 * with an APB slave for the registers.
 * Assumes an APB master on clk_sys and sync inputs synchronous to clk_sys.
 */
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "tb_ctrl_defines.svh"

// Behaviour
// RL1: Sync-out select 10 pulses sync out at counter equal compare-B; 11 holds it low.
// RL2: Period load select 0 copies shadow period to active period at counter zero.
// RL3: In shadow mode, period register reads and writes access the shadow copy.
// RL4: Period load select 1 makes a period write update the active period at once.
// RL5: In immediate mode, period reads and writes access the active period directly.
// RL6: Phase load enable 0 never loads the counter from phase.
// RL7: Phase load enable 1 loads counter from phase on any sync pulse.
// RL8: A new count mode takes effect at the next time-base clock edge.
// RL9: A mode change keeps the counter value; no reload or clear.
// RL10: Count mode 00 up, 01 down, 10 up-down.
// RL11: Count mode 11 freezes the counter and is the reset mode.
// RL12: Software sets the count mode once during configuration.
// RL13: Sync-out select 01 pulses sync out when the counter equals zero.
// RL14: Writing 1 to software sync gives one pulse ORed with sync in; reads 0.
// RL15: Sync-out select 00 passes the combined sync input to sync out.
// RL16: Up wraps at period, down reloads at zero, up-down reverses at ends.
module pwm_time_base_control
	import tb_ctrl_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_sys,     // system clock
	input  wire logic              rst_b,       // asynchronous reset, active low
	input  wire logic              psel,        // APB select
	input  wire logic              penable,     // APB access phase
	input  wire logic              pwrite,      // APB direction
	input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
	input  wire logic [31:0]       pwdata,      // APB write data
	output logic      [31:0]       prdata,      // APB read data
	output logic                   pready,      // APB ready
	output logic                   pslverr,     // APB error
	input  wire logic              syncIn,      // sync pulse from previous module
	output logic                   syncOut,     // sync pulse to next module
	output logic      [CNT_W-1:0]  countValue,  // time-base counter
	output logic                   countUp,     // counter direction, high when up
	output logic                   cmpBMatch    // counter equals compare-B
);
	initial begin
		if (CNT_W < 2 || CNT_W > 16) $error("pwm_time_base_control: CNT_W out of range");
		if (ADDR_W < 5) $error("pwm_time_base_control: ADDR_W too small");
		if (ADDR_W > 32) $error("pwm_time_base_control: ADDR_W too large");
	end

	// Two-stage reset release; the first stage feeds only the second.
	logic rstMeta_q;
	logic rstSync_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// Every register of this module except the two reset-release stages lives in this one struct; the prescaler keeps its own.
	typedef struct packed {
		logic [15:0]      ctrl;
		logic [15:0]      prescale;
		logic [CNT_W-1:0] prdActive;
		logic [CNT_W-1:0] prdShadow;
		logic [CNT_W-1:0] phase;
		logic [CNT_W-1:0] compare_b_value;
		logic [CNT_W-1:0] count;
		dir_e             dir;
		logic             swSync;
		logic             syncOut;
		logic             cmpBMatch;
		logic [31:0]      rdata;
		logic             ready;
		logic             err;
	} state_s;

	state_s stateQ;
	state_s stateD;

	logic tick;

	tb_prescaler #(
		.DIV_W(16)
	) u_prescaler (
		.clk_sys  (clk_sys),
		.rstSync_b(rstSync_q),
		.divide   (stateQ.prescale),
		.tick     (tick)
	);

	// Decoded control fields and shared arithmetic.
	count_mode_e       mode;
	sync_sel_e         syncSel;
	logic              prdImmediate;
	logic              phaseEnable;
	logic              syncComb;
	logic              atZero;
	logic              atPeriod;
	logic              cmpBHit;
	logic              prdCopy;
	logic              phaseLoad;
	logic              upWrap;
	logic              upDownRise;
	logic [CNT_W-1:0]  countInc;
	logic [CNT_W-1:0]  countDec;
	logic [CNT_W-1:0]  wrValue;
	logic              access;
	logic              wrAccess;
	logic              rdAccess;
	logic [ADDR_W-1:0] addr;
	logic              selCtrl;
	logic              selPeriod;
	logic              selPhase;
	logic              selCmpB;
	logic              selCount;
	logic              selPrescale;
	logic              selMapped;
	logic              wrCtrl;
	logic              wrPrdActive;
	logic              wrPrdShadow;
	logic              wrPhase;
	logic              wrCmpB;
	logic              wrCount;
	logic              wrPrescale;

	assign mode         = count_mode_e'(stateQ.ctrl[`POS_CNT_MODE +: 2]);
	assign syncSel      = sync_sel_e'(stateQ.ctrl[`POS_SYNC_SEL +: 2]);
	assign prdImmediate = stateQ.ctrl[`BIT_PRD_LD];
	assign phaseEnable  = stateQ.ctrl[`BIT_PHS_EN];
	assign syncComb     = syncIn | stateQ.swSync; // RL14
	assign atZero       = (stateQ.count == '0);
	assign atPeriod     = (stateQ.count == stateQ.prdActive);
	assign cmpBHit      = (stateQ.count == stateQ.compare_b_value);
	assign countInc     = stateQ.count + {{(CNT_W-1){1'b0}}, 1'b1};
	assign countDec     = stateQ.count - {{(CNT_W-1){1'b0}}, 1'b1};
	assign wrValue      = pwdata[CNT_W-1:0];

	// The copy uses this tick's active period, so the new value governs from the next tick.
	assign prdCopy      = tick & ~prdImmediate & atZero; // RL2
	assign phaseLoad    = phaseEnable & syncComb; // RL7 RL6
	// In up mode, a count above the period, left by a period write, wraps at once instead of running on.
	assign upWrap       = (stateQ.count >= stateQ.prdActive);
	assign upDownRise   = (stateQ.dir == DIR_UP && !atPeriod) || atZero;

	// A transfer is taken once, in the access cycle before ready; the ready cycle is idle.
	assign access       = psel & penable & ~stateQ.ready;
	assign wrAccess     = access & pwrite;
	assign rdAccess     = access & ~pwrite;
	assign addr         = paddr;

	// Address decode; any other offset answers with an error and changes nothing.
	assign selCtrl      = (addr == ADDR_W'(`OFS_TIME_BASE_CONTROL));
	assign selPeriod    = (addr == ADDR_W'(`OFS_PERIOD_VALUE));
	assign selPhase     = (addr == ADDR_W'(`OFS_PHASE_VALUE));
	assign selCmpB      = (addr == ADDR_W'(`OFS_COMPARE_B_VALUE));
	assign selCount     = (addr == ADDR_W'(`OFS_COUNT_VALUE));
	assign selPrescale  = (addr == ADDR_W'(`OFS_PRESCALE));
	assign selMapped    = selCtrl | selPeriod | selPhase | selCmpB |
		selCount | selPrescale;

	// The period write is steered by the load select in force during the access.
	assign wrCtrl       = wrAccess & selCtrl;
	assign wrPrdActive  = wrAccess & selPeriod & prdImmediate; // RL4
	assign wrPrdShadow  = wrAccess & selPeriod & ~prdImmediate; // RL3
	assign wrPhase      = wrAccess & selPhase;
	assign wrCmpB       = wrAccess & selCmpB;
	assign wrCount      = wrAccess & selCount;
	assign wrPrescale   = wrAccess & selPrescale;

	always_comb begin
		stateD        = stateQ;
		stateD.ready  = 1'b0;
		stateD.err    = 1'b0;
		stateD.swSync = 1'b0;

		// Sync output selection; registered so the pin comes from a flip-flop.
		case (syncSel)
			SYNC_PASS: begin
				stateD.syncOut = syncComb; // RL15
			end
			SYNC_ZERO: begin
				stateD.syncOut = tick & atZero; // RL13
			end
			SYNC_COMPARE_B_VALUE: begin
				stateD.syncOut = tick & cmpBHit; // RL1
			end
			SYNC_OFF: begin
				stateD.syncOut = 1'b0; // RL1
			end
			default: begin
				stateD.syncOut = 1'b0;
			end
		endcase
		stateD.cmpBMatch = cmpBHit;

		// Counter advances only on time-base ticks, so a mode write lands at the next edge.
		if (tick) begin // RL8
			if (prdCopy) begin
				stateD.prdActive = stateQ.prdShadow; // RL2
			end
			case (mode) // RL10 RL9
				CNT_UP: begin
					stateD.dir = DIR_UP;
					if (upWrap) begin // RL16
						stateD.count = '0;
					end else begin
						stateD.count = countInc;
					end
				end
				CNT_DOWN: begin
					stateD.dir = DIR_DOWN;
					if (atZero) begin // RL16
						stateD.count = stateQ.prdActive;
					end else begin
						stateD.count = countDec;
					end
				end
				CNT_UPDOWN: begin
					if (upDownRise) begin // RL16
						stateD.dir   = DIR_UP;
						stateD.count = countInc;
					end else begin
						stateD.dir   = DIR_DOWN;
						stateD.count = countDec;
					end
				end
				CNT_FREEZE: begin
					stateD.count = stateQ.count; // RL11
				end
				default: begin
					stateD.count = stateQ.count;
				end
			endcase
		end

		// Phase load wins over counting, since a sync realigns the whole chain.
		if (phaseLoad) begin // RL7 RL6
			stateD.count = stateQ.phase;
		end

		// Writes commit at the taking edge; ready rises at that same edge.
		if (access) begin
			stateD.ready = 1'b1;
			stateD.err   = ~selMapped;
			stateD.rdata = 32'h0000_0000;
		end

		if (wrCtrl) begin
			stateD.ctrl   = pwdata[15:0] & `CTRL_WRITE_MASK;
			stateD.swSync = pwdata[`BIT_SW_SYNC]; // RL14
		end
		if (wrPrdActive) begin
			stateD.prdActive = wrValue; // RL4 RL5
		end
		if (wrPrdShadow) begin
			stateD.prdShadow = wrValue; // RL3
		end
		if (wrPhase) begin
			stateD.phase = wrValue;
		end
		if (wrCmpB) begin
			stateD.compare_b_value = wrValue;
		end
		if (wrCount) begin
			stateD.count = wrValue;
		end
		if (wrPrescale) begin
			stateD.prescale = pwdata[15:0];
		end

		// Reads return zero in every bit that the register does not hold.
		if (rdAccess) begin
			if (selCtrl) begin
				stateD.rdata = {16'h0000, stateQ.ctrl}; // RL14
			end
			if (selPeriod && prdImmediate) begin
				stateD.rdata = 32'(stateQ.prdActive); // RL5
			end
			if (selPeriod && !prdImmediate) begin
				stateD.rdata = 32'(stateQ.prdShadow); // RL3
			end
			if (selPhase) begin
				stateD.rdata = 32'(stateQ.phase);
			end
			if (selCmpB) begin
				stateD.rdata = 32'(stateQ.compare_b_value);
			end
			if (selCount) begin
				stateD.rdata = {15'h0000, stateQ.dir == DIR_UP, 16'(stateQ.count)};
			end
			if (selPrescale) begin
				stateD.rdata = {16'h0000, stateQ.prescale};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			stateQ.ctrl      <= `CTRL_RESET; // RL11
			stateQ.prescale  <= `PRESCALE_RESET;
			stateQ.prdActive <= '0;
			stateQ.prdShadow <= '0;
			stateQ.phase     <= '0;
			stateQ.compare_b_value      <= '0;
			stateQ.count     <= '0;
			stateQ.dir       <= DIR_UP;
			stateQ.swSync    <= 1'b0;
			stateQ.syncOut   <= 1'b0;
			stateQ.cmpBMatch <= 1'b0;
			stateQ.rdata     <= '0;
			stateQ.ready     <= 1'b0;
			stateQ.err       <= 1'b0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign prdata     = stateQ.rdata;
	assign pready     = stateQ.ready;
	assign pslverr    = stateQ.err;
	assign syncOut    = stateQ.syncOut;
	assign countValue = stateQ.count;
	assign countUp    = (stateQ.dir == DIR_UP);
	assign cmpBMatch  = stateQ.cmpBMatch;

endmodule // pwm_time_base_control

// ### rtl/tb_ctrl_defines.svh
/*
 * Register offsets, field positions, reset values and write mask of the time-base control block.
 * Assumes inclusion from rtl files only; definitions only.
 */
`ifndef TB_CTRL_DEFINES_SVH
`define TB_CTRL_DEFINES_SVH

`define OFS_TIME_BASE_CONTROL 12'h000
`define OFS_PERIOD_VALUE      12'h004
`define OFS_PHASE_VALUE       12'h008
`define OFS_COMPARE_B_VALUE   12'h00c
`define OFS_COUNT_VALUE       12'h010
`define OFS_PRESCALE          12'h014

`define BIT_SW_SYNC           6
`define POS_SYNC_SEL          4
`define BIT_PRD_LD            3
`define BIT_PHS_EN            2
`define POS_CNT_MODE          0

`define CTRL_RESET            16'h0003
`define PRESCALE_RESET        16'h0000
`define CTRL_WRITE_MASK       16'h003f

`endif

// ### rtl/tb_ctrl_pkg.sv
/*
 * Types shared by the time-base control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tb_ctrl_pkg;

	typedef enum logic [1:0] {
		CNT_UP     = 2'h0,
		CNT_DOWN   = 2'h1,
		CNT_UPDOWN = 2'h2,
		CNT_FREEZE = 2'h3
	} count_mode_e;

	typedef enum logic [1:0] {
		SYNC_PASS  = 2'h0,
		SYNC_ZERO  = 2'h1,
		SYNC_COMPARE_B_VALUE  = 2'h2,
		SYNC_OFF   = 2'h3
	} sync_sel_e;

	typedef enum logic [1:0] {
		DIR_UP   = 2'h1,
		DIR_DOWN = 2'h2
	} dir_e;

endpackage

// ### rtl/tb_prescaler.sv
/*
 * Time-base clock enable generator: one pulse every (divide+1) system clocks.
 * Assumes a synchronous reset copy and a divide value steady between writes.
 */
`timescale 1ns/1ps
`include "tb_ctrl_defines.svh"

module tb_prescaler
	import tb_ctrl_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input  wire logic             clk_sys,    // system clock
	input  wire logic             rstSync_b,  // synchronised reset, active low
	input  wire logic [DIV_W-1:0] divide,     // divide minus one
	output logic                  tick        // one-cycle time-base clock edge
);
	initial begin
		if (DIV_W < 1 || DIV_W > 16) $error("tb_prescaler: DIV_W out of range");
	end

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} state_s;

	state_s stateQ;
	state_s stateD;

	always_comb begin
		stateD = stateQ;
		stateD.tick = 1'b0;
		if (stateQ.cnt >= divide) begin
			stateD.cnt  = '0;
			stateD.tick = 1'b1;
		end else begin
			stateD.cnt = stateQ.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_b) begin
		if (!rstSync_b) begin
			stateQ <= '0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign tick = stateQ.tick;

endmodule // tb_prescaler

// ### testbench/sync_neighbour.sv
/* Neighbouring module on the sync chain: sends sync pulses on request, counts ours.
   Assumes a one-cycle pulse is a whole sync event. */
`timescale 1ns/1ps
module sync_neighbour (
	input  wire logic       clk_sys,  // system clock
	input  wire logic       syncOut,  // pulses from the block
	output logic            syncIn,   // pulses to the block
	output logic      [7:0] seen      // pulses received
);
	initial begin
		syncIn = 1'b0;
		seen = 8'h00;
	end
	task automatic pulse();
		@(posedge clk_sys);
		syncIn <= 1'b1;
		@(posedge clk_sys);
		syncIn <= 1'b0;
	endtask
	always @(posedge clk_sys) begin
		if (syncOut) seen <= seen + 8'h01;
	end
endmodule // sync_neighbour

// ### testbench/pwm_time_base_control_checker.sv
/* Port assertions for the time-base control block.
   Assumes writes land at the access edge and a tick every clock. */
`timescale 1ns/1ps
module pwm_time_base_control_checker #(
	parameter int CNT_W = 16,
	parameter int ADDR_W = 12
) (
	input wire logic              clk_sys,    // clock
	input wire logic              rst_b,      // reset
	input wire logic              psel,       // select
	input wire logic              penable,    // access
	input wire logic              pwrite,     // direction
	input wire logic [ADDR_W-1:0] paddr,      // address
	input wire logic [31:0]       pwdata,     // write data
	input wire logic              pready,     // ready
	input wire logic              pslverr,    // error
	input wire logic              syncIn,     // sync in
	input wire logic              syncOut,    // sync out
	input wire logic [CNT_W-1:0]  countValue, // counter
	input wire logic              cmpBMatch   // compare-B match
);
	logic [15:0] ctrl_q;
	logic [15:0] phase_q;
	wire logic [1:0] mode = ctrl_q[1:0];
	wire logic [1:0] sel = ctrl_q[5:4];
	wire logic wrAcc = psel && penable && !pready && pwrite;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= 16'h0003;
			phase_q <= 16'h0000;
		end else if (wrAcc && paddr == 12'h000) ctrl_q <= pwdata[15:0];
		else if (wrAcc && paddr == 12'h008) phase_q <= pwdata[15:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence accessS;
		psel && penable && !pready;
	endsequence
	wait_state_a: assert property (accessS |=> pready) else $error("no ready");
	unmapped_err_a: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no err");
	hold_frozen_a: assert property (mode == 2'h3 && !ctrl_q[2] && !psel |=> $stable(countValue))
		else $error("frozen counter moved");
	up_count_a: assert property (mode == 2'h0 && !ctrl_q[2] |=>
		countValue == $past(countValue) + 16'h1 || countValue == 16'h0) else $error("bad up");
	down_count_a: assert property (mode == 2'h1 && !ctrl_q[2] |=>
		countValue == $past(countValue) - 16'h1 || $past(countValue) == 16'h0) else $error("bad down");
	pass_sync_a: assert property (sel == 2'h0 && syncIn |=> syncOut) else $error("no pass");
	sync_off_a: assert property (sel == 2'h3 && $past(sel) == 2'h3 |-> !syncOut) else $error("off");
	zero_sync_a: assert property (sel == 2'h1 && countValue == 16'h0 |=> syncOut) else $error("z");
	compare_b_value_sync_a: assert property (sel == 2'h2 && $past(sel) == 2'h2 && cmpBMatch |-> syncOut)
		else $error("no compare sync");
	phase_load_a: assert property (ctrl_q[2] && syncIn |=> countValue == phase_q)
		else $error("no phase load");
endmodule // pwm_time_base_control_checker
bind pwm_time_base_control pwm_time_base_control_checker #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk (
	.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.syncIn, .syncOut, .countValue, .cmpBMatch);

// ### testbench/test_pwm_time_base_control.sv
/* Bench for the time-base control block: APB tasks, sync partner, queued read checks.
   Assumes one wait state on APB and prescale left at zero, so a tick every clock. */
`timescale 1ns/1ps
module test_pwm_time_base_control;
	logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
	logic        syncIn, syncOut, countUp, cmpBMatch;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] countValue, p, q;
	logic [7:0]  seen;
	logic [32:0] notes[$];
	int          seed = 32'ha1da;
	int          err_count, comparisons, cycles;
	pwm_time_base_control dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .syncIn, .syncOut, .countValue, .countUp, .cmpBMatch);
	sync_neighbour nb (.clk_sys, .syncOut, .syncIn, .seen);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (!pready) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0, d});
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		notes.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic settle();
		repeat (2) @(negedge clk_sys);
	endtask
	// Largest count seen, and whether the counter was ever heading down.
	task automatic span(input logic [15:0] mx, input logic dn);
		logic [15:0] m;
		logic d;
		m = 16'h0;
		d = 1'b0;
		repeat (24) begin
			@(negedge clk_sys);
			if (countValue > m) m = countValue;
			if (countUp === 1'b0) d = 1'b1;
		end
		check({m, d}, {mx, dn});
	endtask
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite) check({pslverr, prdata}, notes.pop_front());
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			results();
		end
	end
	initial begin
		{psel, penable, pwrite, rst_b} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(12'h000, 33'h3);
		rd(12'h020, 33'h100000000);
		{q, p} = $random(seed);
		wr(12'h000, 16'h0007);
		wr(12'h008, p);
		nb.pulse();
		settle();
		check(countValue, p);
		wr(12'h000, 16'h0003);
		wr(12'h008, q);
		nb.pulse();
		settle();
		check(countValue, p);
		wr(12'h000, 16'h0047);
		settle();
		check(countValue, q);
		rd(12'h000, 33'h7);
		wr(12'h000, 16'h0033);
		nb.pulse();
		settle();
		check(seen, 8'h03);
		wr(12'h00c, 16'h2);
		wr(12'h010, 16'h2);
		settle();
		check(cmpBMatch, 1'b1);
		wr(12'h010, 16'h0);
		wr(12'h004, 16'h5);
		rd(12'h004, 33'h5);
		wr(12'h000, 16'h0020);
		span(16'h5, 1'b0);
		wr(12'h004, 16'h2);
		rd(12'h004, 33'h2);
		wr(12'h000, 16'h000b);
		wr(12'h010, 16'h0);
		wr(12'h004, 16'h3);
		rd(12'h004, 33'h3);
		wr(12'h000, 16'h0018);
		span(16'h3, 1'b0);
		wr(12'h000, 16'h001a);
		span(16'h3, 1'b1);
		wr(12'h000, 16'h0019);
		span(16'h3, 1'b1);
		results();
	end
endmodule // test_pwm_time_base_control
